// >>> verilog/dual_gpio_ports.sv
// Dual GPIO ports, an 8-bit wide port and a 6-bit narrow port, on APB.
// Assumes pad inputs are synchronous to core_clk_i and pads are external.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module dual_gpio_ports
   import gpio_pkg::*;
#(
   parameter int WIDE = WIDE_W,
   parameter int NARROW = NARROW_W
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic srst_i,
   // APB slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Wide port pads.
   input wire logic [WIDE-1:0] wide_pin_i,
   output logic [WIDE-1:0] wide_pin_o,
   output logic [WIDE-1:0] wide_pin_oe_o,
   // Narrow port pads.
   input wire logic [NARROW-1:0] narrow_pin_i,
   output logic [NARROW-1:0] narrow_pin_o,
   output logic [NARROW-1:0] narrow_pin_oe_o,
   // Alternate functions of the narrow port.
   input wire logic timer_zero_out_i,
   output logic stop_recovery_n_o,
   output logic interrupt_request_three_o,
   output logic cmp_ref_o,
   output logic cmp_sig_o,
   output logic interrupt_request_one_o,
   output logic interrupt_request_four_o
);
   // Register storage.
   logic [WIDE-1:0] wide_drive_q, wide_dir_q, wide_alt_q, wide_od_q;
   logic [NARROW-1:0] narrow_drive_q, narrow_dir_q, narrow_alt_q;
   logic [WIDE-1:0] wide_in_q;
   logic [NARROW-1:0] narrow_in_q;
   logic [31:0] rdata_q;
   logic slverr_q;
   logic [7:0] idx;
   logic wr_en, rd_en, hit;
   logic [NARROW-1:0] narrow_alt_out_en, narrow_alt_val;
   logic [NARROW-1:0] narrow_od;

   // Extracts the register index from a byte address.
   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[9:2];
   endfunction

   // Tells whether an index names a register of this block.
   function automatic logic is_mapped(input logic [7:0] i);
      is_mapped = (i >= IDX_WIDE_PIN_LEVELS) && (i <= IDX_WIDE_OPEN_DRAIN);
   endfunction

   // Zero-wait APB: the access cycle always completes at once.
   assign idx = reg_index(paddr_i);
   assign hit = is_mapped(idx) && (paddr_i[ADDR_W-1:10] == '0);
   assign wr_en = psel_i & penable_i & pwrite_i & hit & pstrb_i[0];
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;
   assign pready_o = 1'b1;
   assign prdata_o = rdata_q;
   assign pslverr_o = psel_i & penable_i & ~hit;

   // Input value registers sample pad levels every cycle.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wide_in_q <= '0;
         narrow_in_q <= '0;
      end else begin
         wide_in_q <= wide_pin_i;
         narrow_in_q <= narrow_pin_i;
      end
   end

   // Wide port writable registers.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wide_drive_q <= RST_DRIVE[WIDE-1:0];
         wide_dir_q <= RST_DIR[WIDE-1:0];
         wide_alt_q <= RST_ALT[WIDE-1:0];
         wide_od_q <= RST_OD[WIDE-1:0];
      end else if (wr_en) begin
         case (idx)
            IDX_WIDE_DRIVE_VALUES: wide_drive_q <= pwdata_i[WIDE-1:0];
            IDX_WIDE_DIRECTION: wide_dir_q <= pwdata_i[WIDE-1:0];
            IDX_WIDE_ALT_FUNCTION: wide_alt_q <= pwdata_i[WIDE-1:0];
            IDX_WIDE_OPEN_DRAIN: wide_od_q <= pwdata_i[WIDE-1:0];
            default: ;
         endcase
      end
   end

   // Narrow port writable registers; bits above the port read as zero.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         narrow_drive_q <= RST_DRIVE[NARROW-1:0];
         narrow_dir_q <= RST_DIR[NARROW-1:0];
         narrow_alt_q <= RST_ALT[NARROW-1:0];
      end else if (wr_en) begin
         case (idx)
            IDX_NARROW_DRIVE_VALUES: narrow_drive_q <= pwdata_i[NARROW-1:0];
            IDX_NARROW_DIRECTION: narrow_dir_q <= pwdata_i[NARROW-1:0];
            IDX_NARROW_ALT_FUNCTION: narrow_alt_q <= pwdata_i[NARROW-1:0];
            default: ;
         endcase
      end
   end

   // Read data is registered in the setup cycle so it stands in access.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_en) begin
         rdata_q <= 32'h0000_0000;
         case (idx)
            IDX_WIDE_PIN_LEVELS: rdata_q[WIDE-1:0] <= wide_in_q;
            IDX_WIDE_DRIVE_VALUES: rdata_q[WIDE-1:0] <= wide_drive_q;
            IDX_WIDE_DIRECTION: rdata_q[WIDE-1:0] <= wide_dir_q;
            IDX_WIDE_ALT_FUNCTION: rdata_q[WIDE-1:0] <= wide_alt_q;
            IDX_WIDE_OPEN_DRAIN: rdata_q[WIDE-1:0] <= wide_od_q;
            IDX_NARROW_PIN_LEVELS: rdata_q[NARROW-1:0] <= narrow_in_q;
            IDX_NARROW_DRIVE_VALUES: rdata_q[NARROW-1:0] <= narrow_drive_q;
            IDX_NARROW_DIRECTION: rdata_q[NARROW-1:0] <= narrow_dir_q;
            IDX_NARROW_ALT_FUNCTION: rdata_q[NARROW-1:0] <= narrow_alt_q;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Only bit 1 of the narrow port has an output special function.
   always_comb begin
      narrow_alt_out_en = '0;
      narrow_alt_val = '0;
      narrow_od = '0;
      narrow_alt_out_en[NB_TIMER] = narrow_alt_q[NB_TIMER];
      narrow_alt_val[NB_TIMER] = timer_zero_out_i;
      narrow_od[NB_PULLDOWN] = 1'b1;
   end

   // Input special functions apply when the bit is input with alt set.
   // The recovery line idles high so a plain I/O bit never wakes the core.
   always_comb begin
      stop_recovery_n_o = 1'b1;
      if (narrow_alt_q[NB_RECOVERY] & ~narrow_dir_q[NB_RECOVERY]) begin
         stop_recovery_n_o = narrow_in_q[NB_RECOVERY];
      end
      interrupt_request_three_o = narrow_alt_q[NB_INTERRUPT_REQUEST_THREE] &
         ~narrow_dir_q[NB_INTERRUPT_REQUEST_THREE] & narrow_in_q[NB_INTERRUPT_REQUEST_THREE];
      cmp_ref_o = narrow_alt_q[NB_CMP_REF] & ~narrow_dir_q[NB_CMP_REF] &
         narrow_in_q[NB_CMP_REF];
      cmp_sig_o = narrow_alt_q[NB_CMP_SIG] & ~narrow_dir_q[NB_CMP_SIG] &
         narrow_in_q[NB_CMP_SIG];
      interrupt_request_one_o = cmp_sig_o;
      interrupt_request_four_o = cmp_sig_o;
   end

   // Wide port pin cells, one per bit so no bit reaches another.
   for (genvar w = 0; w < WIDE; w++) begin : g_wide
      gpio_pin_cell u_cell (
         .dir_out_i(wide_dir_q[w]),
         .drive_val_i(wide_drive_q[w]),
         .open_drain_i(wide_od_q[w]),
         .alt_out_en_i(1'b0),
         .alt_out_i(1'b0),
         .pin_o(wide_pin_o[w]),
         .pin_oe_o(wide_pin_oe_o[w])
      );
   end

   // Narrow port pin cells; bit 5 is fixed open-drain.
   for (genvar n = 0; n < NARROW; n++) begin : g_narrow
      gpio_pin_cell u_cell (
         .dir_out_i(narrow_dir_q[n]),
         .drive_val_i(narrow_drive_q[n]),
         .open_drain_i(narrow_od[n]),
         .alt_out_en_i(narrow_alt_out_en[n]),
         .alt_out_i(narrow_alt_val[n]),
         .pin_o(narrow_pin_o[n]),
         .pin_oe_o(narrow_pin_oe_o[n])
      );
   end
   // Fourteen lines in total with the default widths; nine indices used.
endmodule

// >>> include/gpio_pkg.sv
// Package of register offsets, widths and reset values for the dual GPIO.
// Assumes a 32-bit APB slave decodes byte addresses word aligned.
package gpio_pkg;
   // Printed offsets are not multiples of four, so they are indices.
   localparam logic [7:0] IDX_WIDE_PIN_LEVELS = 8'hd0;
   localparam logic [7:0] IDX_WIDE_DRIVE_VALUES = 8'hd1;
   localparam logic [7:0] IDX_WIDE_DIRECTION = 8'hd2;
   localparam logic [7:0] IDX_WIDE_ALT_FUNCTION = 8'hd3;
   localparam logic [7:0] IDX_NARROW_PIN_LEVELS = 8'hd4;
   localparam logic [7:0] IDX_NARROW_DRIVE_VALUES = 8'hd5;
   localparam logic [7:0] IDX_NARROW_DIRECTION = 8'hd6;
   localparam logic [7:0] IDX_NARROW_ALT_FUNCTION = 8'hd7;
   // Open-drain select for the wide port, an extra register.
   localparam logic [7:0] IDX_WIDE_OPEN_DRAIN = 8'hd8;
   localparam int ADDR_W = 12;
   localparam int WIDE_W = 8;
   localparam int NARROW_W = 6;
   // Reset values: all inputs, no special function, push-pull.
   localparam logic [7:0] RST_DRIVE = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_ALT = 8'h00;
   localparam logic [7:0] RST_OD = 8'h00;
   // Narrow-port bit positions with defined special functions.
   localparam int NB_RECOVERY = 0;
   localparam int NB_TIMER = 1;
   localparam int NB_INTERRUPT_REQUEST_THREE = 2;
   localparam int NB_CMP_REF = 3;
   localparam int NB_CMP_SIG = 4;
   localparam int NB_PULLDOWN = 5;
endpackage

// >>> verilog/gpio_pin_cell.sv
// One GPIO pin cell: direction, drive value, open-drain and alternate out.
// Assumes the pad resolves the wire from pin_o and pin_oe_o.
`timescale 1ns/1ps
module gpio_pin_cell (
   // Configuration.
   input wire logic dir_out_i,
   input wire logic drive_val_i,
   input wire logic open_drain_i,
   input wire logic alt_out_en_i,
   input wire logic alt_out_i,
   // Pad side.
   output logic pin_o,
   output logic pin_oe_o
);
   logic val;
   // Open-drain only drives the low level; high is released to the pad.
   always_comb begin
      val = alt_out_en_i ? alt_out_i : drive_val_i;
      pin_o = val;
      pin_oe_o = dir_out_i & (~open_drain_i | ~val);
   end
endmodule

// >>> sim/gpio_pad_model.sv
// Far-side load of the port pins, one instance for each port.
// Assumes the load drives ext_i and yields wherever the block drives.
`timescale 1ns/1ps
module gpio_pad_model #(parameter int W = 8) (
   // Block side.
   input wire logic [W-1:0] drv_i,
   input wire logic [W-1:0] oe_i,
   // Load side.
   input wire logic [W-1:0] ext_i,
   output logic [W-1:0] level_o
);
   // A driven bit shows the drive, a released bit the load's own level.
   assign level_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// >>> sim/dual_gpio_properties.sv
// Checker of port relations of the dual GPIO block.
// Assumes it is bound to dual_gpio_ports and sees its ports only.
`timescale 1ns/1ps
module dual_gpio_properties
   import gpio_pkg::*;
#(parameter int WIDE = WIDE_W, parameter int NARROW = NARROW_W) (
   // Clock, reset and APB.
   input wire logic core_clk_i, srst_i, psel_i, penable_i, pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o, pslverr_o,
   // Pads and alternate functions.
   input wire logic [WIDE-1:0] wide_pin_o, wide_pin_oe_o,
   input wire logic [NARROW-1:0] narrow_pin_o, narrow_pin_oe_o,
   input wire logic stop_recovery_n_o, interrupt_request_three_o,
   input wire logic cmp_ref_o, cmp_sig_o,
   input wire logic interrupt_request_one_o, interrupt_request_four_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   // Nine word indices are mapped, the extra open-drain one included.
   wire mapped = paddr_i[ADDR_W-1:2] >= IDX_WIDE_PIN_LEVELS &&
      paddr_i[ADDR_W-1:2] <= IDX_WIDE_OPEN_DRAIN;
   sequence s_access; psel_i && penable_i; endsequence
   sequence s_read; psel_i && penable_i && !pwrite_i; endsequence
   a_ready_access: assert property (s_access |-> pready_o)
      else $error("pready low in access phase");
   a_bad_addr: assert property (s_access |-> pslverr_o == !mapped)
      else $error("pslverr does not match the address map");
   a_upper_zero: assert property (s_read |-> prdata_o[31:8] == 24'h0)
      else $error("read data has upper bits set");
   // Pad drive other than narrow_pin_o comes from registers only, so it moves only after writes.
   a_pins_after_write: assert property ($changed({wide_pin_o,
      wide_pin_oe_o, narrow_pin_oe_o}) |-> $past(psel_i && penable_i &&
      pwrite_i))
      else $error("pad drive changed without a write");
   a_rdata_holds: assert property (!(psel_i && !penable_i) |=>
      $stable(prdata_o))
      else $error("read data moved outside a setup cycle");
   a_bit5_low_only: assert property (narrow_pin_oe_o[NB_PULLDOWN] |->
      !narrow_pin_o[NB_PULLDOWN])
      else $error("narrow bit 5 drives high");
   a_recovery_in: assert property (!stop_recovery_n_o |->
      !narrow_pin_oe_o[NB_RECOVERY])
      else $error("recovery active on an output bit");
   a_interrupt_request_three_in: assert property (interrupt_request_three_o |->
      !narrow_pin_oe_o[NB_INTERRUPT_REQUEST_THREE])
      else $error("request three active on an output bit");
   a_cmp_ref_in: assert property (cmp_ref_o |->
      !narrow_pin_oe_o[NB_CMP_REF])
      else $error("comparator reference on an output bit");
   a_cmp_route: assert property (interrupt_request_one_o == cmp_sig_o &&
      interrupt_request_four_o == cmp_sig_o)
      else $error("requests one and four differ from comparator signal");
endmodule
bind dual_gpio_ports dual_gpio_properties #(.WIDE(WIDE), .NARROW(NARROW))
   dual_gpio_properties_i (.core_clk_i, .srst_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .wide_pin_o,
   .wide_pin_oe_o, .narrow_pin_o, .narrow_pin_oe_o, .stop_recovery_n_o,
   .interrupt_request_three_o, .cmp_ref_o, .cmp_sig_o,
   .interrupt_request_one_o, .interrupt_request_four_o);

// >>> sim/dual_gpio_ports_tb.sv
// Self-checking bench of the dual GPIO ports over APB.
// Assumes the pad models stand for the load on every pin.
`timescale 1ns/1ps
module dual_gpio_ports_tb;
   import gpio_pkg::*;
   logic clk, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] strb = 4'hf;
   logic pready, pslverr, tmr = 1'b0, stop_n, interrupt_request_three, cref, csig, interrupt_request_one, interrupt_request_four;
   logic [7:0] w_o, w_oe, w_in, w_ext = 8'ha5;
   logic [5:0] n_o, n_oe, n_in, n_ext = 6'h2a;
   int err_count = 0, n_tests = 0, cyc = 0;
   dual_gpio_ports dual_gpio_ports_i (.core_clk_i(clk), .srst_i(srst),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwdata), .pstrb_i(strb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .wide_pin_i(w_in),
      .wide_pin_o(w_o), .wide_pin_oe_o(w_oe), .narrow_pin_i(n_in),
      .narrow_pin_o(n_o), .narrow_pin_oe_o(n_oe), .timer_zero_out_i(tmr),
      .stop_recovery_n_o(stop_n), .interrupt_request_three_o(interrupt_request_three),
      .cmp_ref_o(cref), .cmp_sig_o(csig), .interrupt_request_one_o(interrupt_request_one),
      .interrupt_request_four_o(interrupt_request_four));
   gpio_pad_model #(.W(8)) wide_pad_i (.drv_i(w_o), .oe_i(w_oe),
      .ext_i(w_ext), .level_o(w_in));
   gpio_pad_model #(.W(6)) narrow_pad_i (.drv_i(n_o), .oe_i(n_oe),
      .ext_i(n_ext), .level_o(n_in));
   // Clock of 10 ns period.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   // One APB transfer, entered just after a rising edge.
   task automatic apb(input logic [11:0] a, input logic w,
         input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk(rd, e);
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      apb(ad(i), 1'b1, d);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({w_oe, n_oe, stop_n}, 32'h1);
      rdc(ad(IDX_WIDE_PIN_LEVELS), 32'ha5);
      rdc(ad(IDX_NARROW_PIN_LEVELS), 32'h2a);
      // Every writable register clears, then holds its own width only.
      for (int i = 1; i < 9; i++) begin
         if (i != 4) begin
            rdc(ad(IDX_WIDE_PIN_LEVELS + 8'(i)), 32'h0);
            wr(IDX_WIDE_PIN_LEVELS + 8'(i), 32'hffffff5a);
            rdc(ad(IDX_WIDE_PIN_LEVELS + 8'(i)),
               (i > 4 && i < 8) ? 32'h1a : 32'h5a);
         end
      end
      wr(IDX_WIDE_PIN_LEVELS, 32'h0);
      rdc(12'h364, 32'h0);
      chk(er, 1'b1);
      wr(IDX_WIDE_OPEN_DRAIN, 32'h0);
      wr(IDX_WIDE_DRIVE_VALUES, 32'h3c);
      wr(IDX_WIDE_DIRECTION, 32'h0f);
      chk({w_oe, w_o & w_oe}, 16'h0f0c);
      rdc(ad(IDX_WIDE_PIN_LEVELS), 32'hac);
      wr(IDX_WIDE_OPEN_DRAIN, 32'h0f);
      chk({w_oe, w_o & w_oe}, 16'h0300);
      rdc(ad(IDX_WIDE_PIN_LEVELS), 32'ha4);
      // A write without its low byte strobe must leave the register alone.
      strb <= 4'h0;
      wr(IDX_WIDE_DRIVE_VALUES, 32'hff);
      strb <= 4'hf;
      rdc(ad(IDX_WIDE_DRIVE_VALUES), 32'h3c);
      wr(IDX_NARROW_ALT_FUNCTION, 32'h0);
      wr(IDX_NARROW_DIRECTION, 32'h21);
      wr(IDX_NARROW_DRIVE_VALUES, 32'h21);
      chk(n_oe, 6'h01);
      wr(IDX_NARROW_DRIVE_VALUES, 32'h0);
      chk({n_oe, n_o & n_oe}, 12'h840);
      rdc(ad(IDX_NARROW_PIN_LEVELS), 32'h0a);
      // Bit 0 is an input with its special function, as before stop.
      wr(IDX_NARROW_DIRECTION, 32'h02);
      wr(IDX_NARROW_ALT_FUNCTION, 32'h1f);
      tmr <= 1'b1;
      @(posedge clk);
      chk({n_oe[1], n_o[1]}, 2'b11);
      tmr <= 1'b0;
      @(posedge clk);
      chk(n_o[1], 1'b0);
      chk({stop_n, interrupt_request_three, cref, csig, interrupt_request_one, interrupt_request_four}, 6'h08);
      n_ext <= 6'h15;
      repeat (3) @(posedge clk);
      chk({stop_n, interrupt_request_three, cref, csig, interrupt_request_one, interrupt_request_four}, 6'h37);
      wr(IDX_NARROW_ALT_FUNCTION, 32'h0);
      chk({stop_n, interrupt_request_three, cref, csig, interrupt_request_one, interrupt_request_four}, 6'h20);
      report_and_stop();
   end
   // A hang is cut short well past the length of the sequence.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
endmodule
